// ---- logic/sewc_sleep_wake.sv ----
// Contract
// - Executing the sleep instruction enters power-down.
// - Entering power-down clears the watchdog count; watchdog keeps running.
// - Entering power-down clears the power-down flag.
// - Entering power-down sets the time-out flag.
// - Sleep stops the main oscillator driver; secondary timer oscillator untouched.
// - Ports hold their pre-sleep drive state during power-down.
// - Watchdog reset never drives the master clear pin low.
// - Pin reset resets device; watchdog or interrupt wake continues execution.
// - Power-down flag set at power-up, cleared on sleep entry.
// - Watchdog wake clears the time-out flag.
// - Only the listed qualifying peripherals may wake the device.
// - Clock-dependent peripherals raise no interrupt during sleep.
// - Sleep prefetches the instruction at PC plus one.
// - Interrupt wakes only if its enable is set, regardless of global enable.
// - Global interrupts off: resume after the sleep instruction.
// - Global interrupts on: run prefetched instruction, then branch to vector.
// - Enabled pending source with globals off: finish sleep, wake at once.
// - Every wake clears the watchdog.
// - Interrupt pending before sleep makes sleep a no-op, no flag changes.
// - Crystal mode waits 1024 oscillator periods after wake; else skipped.
`timescale 1ns/1ps
`default_nettype none

module sewc_sleep_wake (
   input  wire logic        ref_clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        clk_en_in,
   // Avalon-MM slave
   input  wire logic [3:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   output logic [31:0]      avs_readdata_out,
   output logic             avs_waitrequest_out,
   output logic [1:0]       avs_response_out,
   // Core side
   input  wire logic        sleep_exec_in,
   input  wire logic [12:0] pc_in,
   input  wire logic        master_clear_pin_in,
   input  wire logic        watchdog_timer_timeout_in,
   input  wire logic [6:0]  wake_flag_in,
   input  wire logic [6:0]  wake_qualified_in,
   input  wire logic [7:0]  port_drive_in,
   input  wire logic [7:0]  port_oe_in,
   output logic             core_halt_out,
   output logic             core_reset_out,
   output logic             prefetch_req_out,
   output logic [12:0]      prefetch_addr_out,
   output logic             vector_req_out,
   output logic [12:0]      vector_addr_out,
   output logic             watchdog_timer_clear_out,
   output logic             osc_driver_en_out,
   output logic             master_clear_pin_out,
   output logic             master_clear_pin_oe_out,
   output logic [7:0]       port_drive_out,
   output logic [7:0]       port_oe_out,
   output logic             power_down_flag_out,
   output logic             timeout_flag_out
);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic any_wake(input logic [6:0] flg,
                                     input logic [6:0] qual,
                                     input logic [6:0] ena);
      any_wake = |(flg & qual & ena);
   endfunction

   sewc_pkg::sewc_state_type state_ff;
   sewc_pkg::sewc_state_type nxt_state;
   logic [2:0]  ctrl_ff;
   logic [6:0]  enable_ff;
   logic [1:0]  cause_ff;
   logic [1:0]  nxt_cause;
   logic        power_down_ff;
   logic        timeout_ff;
   logic        nxt_power_down;
   logic        nxt_timeout;
   logic [10:0] ost_ff;
   logic        wait_ff;
   logic        wake_req;
   logic        irq_pending;
   logic        sleep_enter;
   logic        bus_req;
   logic        pin_reset;

   // Pin reset counts only while the master clear function is enabled
   assign pin_reset   = !master_clear_pin_in && ctrl_ff[sewc_pkg::CTRL_PIN_RESET_BIT];
   // Only qualified, enabled flags count; global enable is ignored
   assign irq_pending = any_wake(wake_flag_in, wake_qualified_in, enable_ff);
   // Pending before sleep: the sleep completes as a no-op
   assign sleep_enter = (state_ff == sewc_pkg::SEWC_RUN) && sleep_exec_in && !irq_pending;
   assign wake_req    = irq_pending || watchdog_timer_timeout_in;
   assign bus_req     = avs_read_in || avs_write_in;

   ////////////////////////////////////////////////////////////////////////////
   // Sleep sequencer

   always_comb begin
      nxt_state = state_ff;
      nxt_cause = cause_ff;
      unique case (state_ff)
         sewc_pkg::SEWC_RUN: begin
            if (sleep_enter) begin
               nxt_state = sewc_pkg::SEWC_SLEEP;
            end
         end
         sewc_pkg::SEWC_SLEEP: begin
            // Pending enabled source wakes at once after sleep completes
            if (wake_req) begin
               nxt_cause = watchdog_timer_timeout_in ? sewc_pkg::CAUSE_WATCHDOG
                                                     : sewc_pkg::CAUSE_IRQ;
               nxt_state = ctrl_ff[sewc_pkg::CTRL_XTAL_BIT] ? sewc_pkg::SEWC_OST
                                                            : sewc_pkg::SEWC_NEXT;
            end
         end
         sewc_pkg::SEWC_OST: begin
            if (ost_ff == 11'h000) begin
               nxt_state = sewc_pkg::SEWC_NEXT;
            end
         end
         sewc_pkg::SEWC_NEXT: begin
            // Prefetched instruction runs; vector only with globals on
            if (cause_ff == sewc_pkg::CAUSE_IRQ && ctrl_ff[sewc_pkg::CTRL_GLOBAL_IRQ_BIT]) begin
               nxt_state = sewc_pkg::SEWC_VEC;
            end else begin
               nxt_state = sewc_pkg::SEWC_RUN;
            end
         end
         sewc_pkg::SEWC_VEC: begin
            nxt_state = sewc_pkg::SEWC_RUN;
         end
         default: begin
            nxt_state = sewc_pkg::SEWC_RUN;
         end
      endcase
      // Master clear is a true reset in every state, including sleep; done here
      // so halt and oscillator outputs follow the reset on the same edge
      if (pin_reset) begin
         nxt_state = sewc_pkg::SEWC_RUN;
         nxt_cause = sewc_pkg::CAUSE_RESET;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_ff <= sewc_pkg::SEWC_RUN;
         cause_ff <= sewc_pkg::CAUSE_NONE;
      end else if (clk_en_in) begin
         state_ff <= nxt_state;
         cause_ff <= nxt_cause;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ost_ff <= 11'h000;
      end else if (clk_en_in) begin
         if (state_ff == sewc_pkg::SEWC_SLEEP) begin
            ost_ff <= sewc_pkg::OST_LOAD - 11'h001;
         end else if (state_ff == sewc_pkg::SEWC_OST && ost_ff != 11'h000) begin
            ost_ff <= ost_ff - 11'h001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status flags

   // Next values feed both the register and the pins, so the pins change on
   // the same edge as the sequencer instead of one cycle late
   always_comb begin
      nxt_power_down = power_down_ff;
      nxt_timeout    = timeout_ff;
      if (!pin_reset && sleep_enter) begin
         nxt_power_down = 1'b0;
         nxt_timeout    = 1'b1;
      end else if (!pin_reset && state_ff == sewc_pkg::SEWC_SLEEP &&
                   watchdog_timer_timeout_in) begin
         nxt_timeout = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         power_down_ff <= 1'b1;
         timeout_ff    <= 1'b1;
      end else if (clk_en_in) begin
         power_down_ff <= nxt_power_down;
         timeout_ff    <= nxt_timeout;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Core and pin outputs

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         core_halt_out            <= 1'b0;
         core_reset_out           <= 1'b0;
         prefetch_req_out         <= 1'b0;
         prefetch_addr_out        <= 13'h0000;
         vector_req_out           <= 1'b0;
         vector_addr_out          <= sewc_pkg::VECTOR_ADDR;
         watchdog_timer_clear_out <= 1'b0;
         osc_driver_en_out        <= 1'b1;
      end else if (clk_en_in) begin
         // Halt until the clock is back and start-up is over
         core_halt_out     <= (nxt_state == sewc_pkg::SEWC_SLEEP) ||
                              (nxt_state == sewc_pkg::SEWC_OST);
         core_reset_out    <= pin_reset;
         prefetch_req_out  <= sleep_enter;
         if (sleep_enter) begin
            prefetch_addr_out <= pc_in + sewc_pkg::PC_STEP;
         end
         vector_req_out    <= (state_ff == sewc_pkg::SEWC_VEC);
         // Clear on entry and on every wake
         watchdog_timer_clear_out <= sleep_enter ||
                                     (state_ff == sewc_pkg::SEWC_SLEEP &&
                                      (wake_req || pin_reset));
         // Secondary oscillator is outside this block and never gated
         osc_driver_en_out <= !(nxt_state == sewc_pkg::SEWC_SLEEP);
      end
   end

   // The pin is input-only here, so a watchdog reset cannot pull it low
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         master_clear_pin_out    <= 1'b0;
         master_clear_pin_oe_out <= 1'b0;
      end else if (clk_en_in) begin
         master_clear_pin_out    <= 1'b0;
         master_clear_pin_oe_out <= 1'b0;
      end
   end

   // Ports freeze while asleep so loads see no glitch
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         port_drive_out <= 8'h00;
         port_oe_out    <= 8'h00;
      end else if (clk_en_in) begin
         if (!core_halt_out) begin
            port_drive_out <= port_drive_in;
            port_oe_out    <= port_oe_in;
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         power_down_flag_out <= 1'b1;
         timeout_flag_out    <= 1'b1;
      end else if (clk_en_in) begin
         power_down_flag_out <= nxt_power_down;
         timeout_flag_out    <= nxt_timeout;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Avalon-MM slave: one wait cycle, answer on the second edge

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wait_ff <= 1'b0;
      end else if (clk_en_in) begin
         wait_ff <= bus_req && !wait_ff;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         avs_waitrequest_out <= 1'b1;
      end else if (clk_en_in) begin
         avs_waitrequest_out <= !(bus_req && !wait_ff);
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctrl_ff   <= sewc_pkg::CTRL_RESET;
         enable_ff <= sewc_pkg::ENABLE_RESET;
      end else if (clk_en_in) begin
         if (avs_write_in && wait_ff && avs_byteenable_in[0]) begin
            if (avs_address_in == sewc_pkg::ADDR_CTRL) begin
               ctrl_ff <= avs_writedata_in[2:0];
            end
            if (avs_address_in == sewc_pkg::ADDR_ENABLE) begin
               enable_ff <= avs_writedata_in[6:0];
            end
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         avs_readdata_out <= 32'h0000_0000;
         avs_response_out <= 2'h0;
      end else if (clk_en_in) begin
         avs_readdata_out <= 32'h0000_0000;
         avs_response_out <= 2'h0;
         if (avs_read_in && !wait_ff) begin
            unique case (avs_address_in)
               sewc_pkg::ADDR_CTRL:   avs_readdata_out <= {29'h0, ctrl_ff};
               sewc_pkg::ADDR_STATUS: avs_readdata_out <= {29'h0,
                                         state_ff != sewc_pkg::SEWC_RUN, timeout_ff,
                                         power_down_ff};
               sewc_pkg::ADDR_ENABLE: avs_readdata_out <= {25'h0, enable_ff};
               sewc_pkg::ADDR_CAUSE:  avs_readdata_out <= {30'h0, cause_ff};
               default:               avs_response_out <= 2'h2;
            endcase
         end else if (avs_write_in && !wait_ff) begin
            if (avs_address_in != sewc_pkg::ADDR_CTRL &&
                avs_address_in != sewc_pkg::ADDR_ENABLE) begin
               avs_response_out <= 2'h2;
            end
         end
      end
   end

endmodule

`default_nettype wire

// ---- logic/sewc_pkg.sv ----
package sewc_pkg;

   // Avalon-MM word offsets (byte addresses)
   localparam logic [3:0] ADDR_CTRL   = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_ENABLE = 4'h8;
   localparam logic [3:0] ADDR_CAUSE  = 4'hC;

   // Control register fields
   localparam int CTRL_GLOBAL_IRQ_BIT = 0;
   localparam int CTRL_PIN_RESET_BIT  = 1;
   localparam int CTRL_XTAL_BIT       = 2;

   // Status register fields
   localparam int STAT_POWER_DOWN_BIT = 0;
   localparam int STAT_TIMEOUT_BIT    = 1;
   localparam int STAT_SLEEP_BIT      = 2;

   // Wake source indices
   localparam int SRC_COUNT    = 7;
   localparam int SRC_TIMER1   = 0;
   localparam int SRC_USART    = 1;
   localparam int SRC_ADC      = 2;
   localparam int SRC_PINCHG   = 3;
   localparam int SRC_EXTINT   = 4;
   localparam int SRC_CAPTURE  = 5;
   localparam int SRC_SYNC_SER = 6;

   // Reset values
   localparam logic [2:0] CTRL_RESET   = 3'h2;
   localparam logic [6:0] ENABLE_RESET = 7'h00;

   localparam logic [12:0] VECTOR_ADDR = 13'h0004;
   localparam logic [12:0] PC_STEP     = 13'h0001;

   // Oscillator start-up: 1024 oscillator periods, one per core clock here
   localparam int OST_PERIODS = 1024;
   localparam int OST_CYCLES  = OST_PERIODS;
   localparam logic [10:0] OST_LOAD = 11'(OST_CYCLES);

   localparam logic [1:0] CAUSE_NONE  = 2'h0;
   localparam logic [1:0] CAUSE_RESET = 2'h1;
   localparam logic [1:0] CAUSE_WATCHDOG = 2'h2;
   localparam logic [1:0] CAUSE_IRQ   = 2'h3;

   typedef enum logic [2:0] {
      SEWC_RUN   = 3'b000,
      SEWC_SLEEP = 3'b001,
      SEWC_OST   = 3'b010,
      SEWC_NEXT  = 3'b011,
      SEWC_VEC   = 3'b100
   } sewc_state_type;

endpackage

// ---- bench/sewc_sleep_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module sewc_sleep_checker (
   input wire logic        ref_clk_in,
   input wire logic        rst_n_in,
   input wire logic        sleep_exec_in,
   input wire logic [12:0] pc_in,
   input wire logic        core_halt_out,
   input wire logic        prefetch_req_out,
   input wire logic [12:0] prefetch_addr_out,
   input wire logic        vector_req_out,
   input wire logic [12:0] vector_addr_out,
   input wire logic        watchdog_timer_clear_out,
   input wire logic        osc_driver_en_out,
   input wire logic        master_clear_pin_out,
   input wire logic        master_clear_pin_oe_out,
   input wire logic [7:0]  port_drive_out,
   input wire logic [7:0]  port_oe_out,
   input wire logic        power_down_flag_out,
   input wire logic        timeout_flag_out
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   ////////////////////////////////////////
   halt_cause_a: assert property ($rose(core_halt_out) |-> $past(sleep_exec_in))
      else $error("core halted without a sleep instruction");
   dog_entry_a: assert property ($rose(core_halt_out) |-> watchdog_timer_clear_out)
      else $error("watchdog not cleared on sleep entry");
   power_clear_a: assert property ($rose(core_halt_out) |-> !power_down_flag_out)
      else $error("power down flag not cleared on sleep entry");
   to_set_a: assert property ($rose(core_halt_out) |-> timeout_flag_out)
      else $error("timeout flag not set on sleep entry");
   osc_off_a: assert property ($rose(core_halt_out) |-> !osc_driver_en_out)
      else $error("oscillator driver left on in sleep");
   ports_hold_a: assert property (core_halt_out && $past(core_halt_out) |->
      $stable(port_drive_out) && $stable(port_oe_out))
      else $error("port state moved while halted");
   pin_quiet_a: assert property (!master_clear_pin_oe_out || master_clear_pin_out)
      else $error("master clear pin driven low");
   prefetch_pc_a: assert property (prefetch_req_out |-> $rose(core_halt_out)
      && prefetch_addr_out == $past(pc_in) + sewc_pkg::PC_STEP)
      else $error("prefetch address is not the next location");
   vector_addr_a: assert property (vector_req_out |->
      vector_addr_out == sewc_pkg::VECTOR_ADDR && osc_driver_en_out)
      else $error("vector request with wrong address");
endmodule
bind sewc_sleep_wake sewc_sleep_checker sewc_sleep_checker_i (.ref_clk_in, .rst_n_in,
   .sleep_exec_in, .pc_in, .core_halt_out, .prefetch_req_out, .prefetch_addr_out,
   .vector_req_out, .vector_addr_out, .watchdog_timer_clear_out, .osc_driver_en_out,
   .master_clear_pin_out, .master_clear_pin_oe_out, .port_drive_out, .port_oe_out,
   .power_down_flag_out, .timeout_flag_out);
`default_nettype wire

// ---- bench/sewc_wake_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
module sewc_wake_partner (
   input  wire logic      ref_clk_in,
   output var logic       master_clear_pin_out,
   output var logic       watchdog_timer_timeout_out,
   output var logic [6:0] wake_flag_out,
   output var logic [6:0] wake_qualified_out
);
   // Master clear idles high so sleep is never cut short by accident
   initial begin
      master_clear_pin_out = 1'h1;
      watchdog_timer_timeout_out = 1'h0;
      wake_flag_out = 7'h00;
      wake_qualified_out = 7'h7F;
   end
   ////////////////////////////////////////
   task automatic raise_flag(input int src, input logic qual, input int dly);
      repeat (dly) @(posedge ref_clk_in);
      wake_qualified_out[src] <= qual;
      wake_flag_out[src] <= 1'h1;
   endtask
   task automatic clear_flags();
      @(posedge ref_clk_in);
      wake_flag_out <= 7'h00;
      wake_qualified_out <= 7'h7F;
      repeat (3) @(posedge ref_clk_in);
   endtask
   task automatic watchdog_expire(input int dly);
      repeat (dly) @(posedge ref_clk_in);
      watchdog_timer_timeout_out <= 1'h1;
      @(posedge ref_clk_in);
      watchdog_timer_timeout_out <= 1'h0;
   endtask
   task automatic pin_reset(input int len);
      @(posedge ref_clk_in);
      master_clear_pin_out <= 1'h0;
      repeat (len) @(posedge ref_clk_in);
      master_clear_pin_out <= 1'h1;
   endtask
endmodule
`default_nettype wire

// ---- bench/tb_sewc_sleep_wake.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_sewc_sleep_wake;
   logic        ref_clk_in = 1'h0, rst_n_in = 1'h0, clk_en_in = 1'h1, sleep_exec_in = 1'h0;
   logic        avs_read_in = 1'h0, avs_write_in = 1'h0;
   logic [3:0]  avs_address_in = 4'h0, avs_byteenable_in = 4'hF;
   logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out;
   logic [12:0] pc_in = 13'h0, prefetch_addr_out, vector_addr_out;
   logic [7:0]  port_drive_in = 8'h0, port_oe_in = 8'h0, port_drive_out, port_oe_out;
   logic [6:0]  wake_flag_in, wake_qualified_in;
   logic [1:0]  avs_response_out;
   logic        master_clear_pin_in, watchdog_timer_timeout_in, avs_waitrequest_out;
   logic        core_halt_out, core_reset_out, prefetch_req_out, vector_req_out;
   logic        watchdog_timer_clear_out, osc_driver_en_out, power_down_flag_out;
   logic        master_clear_pin_out, master_clear_pin_oe_out, timeout_flag_out;
   logic [33:0] rdq[$];
   logic [12:0] pfq[$], vq[$];
   int          mismatches = 0, cmp_count = 0, clr_cnt = 0;
   always #10 ref_clk_in = ~ref_clk_in;
   sewc_sleep_wake sewc_sleep_wake_i (.ref_clk_in, .rst_n_in, .clk_en_in, .avs_address_in,
      .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
      .avs_waitrequest_out, .avs_response_out, .sleep_exec_in, .pc_in, .master_clear_pin_in,
      .watchdog_timer_timeout_in, .wake_flag_in, .wake_qualified_in, .port_drive_in,
      .port_oe_in, .core_halt_out, .core_reset_out, .prefetch_req_out, .prefetch_addr_out,
      .vector_req_out, .vector_addr_out, .watchdog_timer_clear_out, .osc_driver_en_out,
      .master_clear_pin_out, .master_clear_pin_oe_out, .port_drive_out, .port_oe_out,
      .power_down_flag_out, .timeout_flag_out);
   sewc_wake_partner sewc_wake_partner_i (.ref_clk_in, .wake_flag_out(wake_flag_in),
      .master_clear_pin_out(master_clear_pin_in), .wake_qualified_out(wake_qualified_in),
      .watchdog_timer_timeout_out(watchdog_timer_timeout_in));
   ////////////////////////////////////////
   task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_sim();
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      input logic [33:0] exp);
      int n;
      @(posedge ref_clk_in);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_write_in <= wr;
      avs_read_in <= !wr;
      if (!wr) rdq.push_back(exp);
      n = 0;
      do begin
         @(posedge ref_clk_in);
         n++;
      end while (avs_waitrequest_out !== 1'h0 && n < 64);
      if (n >= 64) chk("bus answer", 34'h0, 34'h1);
      avs_read_in <= 1'h0;
      avs_write_in <= 1'h0;
   endtask
   task automatic do_sleep(input logic enter);
      logic [12:0] pc;
      pc = 13'($urandom);
      @(posedge ref_clk_in);
      sleep_exec_in <= 1'h1;
      pc_in <= pc;
      if (enter) pfq.push_back(pc + sewc_pkg::PC_STEP);
      @(posedge ref_clk_in);
      sleep_exec_in <= 1'h0;
      @(posedge ref_clk_in);
      chk("halt", {33'h0, enter}, {33'h0, core_halt_out});
   endtask
   // Ports wander while asleep so a leaky freeze shows up
   task automatic wait_wake(output int cyc);
      cyc = 0;
      while (core_halt_out !== 1'h0 && cyc < 1500) begin
         @(posedge ref_clk_in);
         port_drive_in <= 8'($urandom);
         port_oe_in <= 8'($urandom);
         cyc++;
      end
      if (cyc >= 1500) chk("wake timeout", 34'h0, 34'h1);
   endtask
   ////////////////////////////////////////
   always @(posedge ref_clk_in) begin
      if (avs_read_in && avs_waitrequest_out === 1'h0)
         chk("read data", rdq.size() > 0 ? rdq.pop_front() : 'x, {avs_response_out, avs_readdata_out});
      if (prefetch_req_out === 1'h1)
         chk("prefetch", {21'h0, pfq.size() > 0 ? pfq.pop_front() : 13'hx}, {21'h0, prefetch_addr_out});
      if (vector_req_out === 1'h1)
         chk("vector", {21'h0, vq.size() > 0 ? vq.pop_front() : 13'hx}, {21'h0, vector_addr_out});
      if (watchdog_timer_clear_out === 1'h1) clr_cnt++;
   end
   initial begin
      #1_000_000;
      mismatches++;
      end_sim();
   end
   initial begin
      int n, src, c0;
      void'($urandom(48295));
      repeat (4) @(posedge ref_clk_in);
      rst_n_in <= 1'h1;
      bus(1'h0, 4'h0, 32'h0, 34'h2);
      bus(1'h0, 4'h4, 32'h0, 34'h3);
      bus(1'h0, 4'h8, 32'h0, 34'h0);
      bus(1'h0, 4'hC, 32'h0, 34'h0);
      bus(1'h0, 4'h2, 32'h0, 34'h200000000);
      bus(1'h1, 4'h4, 32'hFFFFFFFF, 34'h0);
      clk_en_in <= 1'h0;
      repeat (3) @(posedge ref_clk_in);
      clk_en_in <= 1'h1;
      bus(1'h0, 4'h4, 32'h0, 34'h3);
      bus(1'h1, 4'h8, 32'h7F, 34'h0);
      for (src = 0; src < sewc_pkg::SRC_COUNT; src++) begin
         do_sleep(1'h1);
         bus(1'h0, 4'h4, 32'h0, 34'h6);
         c0 = clr_cnt;
         sewc_wake_partner_i.raise_flag(src, 1'h1, src * 5);
         wait_wake(n);
         chk("quick wake", 34'h1, {33'h0, n < 1024});
         bus(1'h0, 4'hC, 32'h0, 34'h3);
         chk("wake clear", 34'h1, {33'h0, clr_cnt > c0});
         sewc_wake_partner_i.clear_flags();
      end
      bus(1'h1, 4'h0, 32'h3, 34'h0);
      do_sleep(1'h1);
      // The word after sleep stands for the no-op that software places there
      vq.push_back(sewc_pkg::VECTOR_ADDR);
      sewc_wake_partner_i.raise_flag($urandom_range(6, 0), 1'h1, 40);
      wait_wake(n);
      repeat (6) @(posedge ref_clk_in);
      chk("vector seen", 34'h0, 34'(vq.size()));
      sewc_wake_partner_i.clear_flags();
      // Disabled source and unqualified source must both leave the core asleep
      bus(1'h1, 4'h8, 32'h7E, 34'h0);
      do_sleep(1'h1);
      sewc_wake_partner_i.raise_flag(0, 1'h1, 0);
      sewc_wake_partner_i.raise_flag(1, 1'h0, 1);
      repeat (60) @(posedge ref_clk_in);
      chk("still asleep", 34'h1, {33'h0, core_halt_out});
      sewc_wake_partner_i.watchdog_expire(5);
      wait_wake(n);
      chk("no pin reset", 34'h0, {33'h0, core_reset_out});
      bus(1'h0, 4'hC, 32'h0, 34'h2);
      bus(1'h0, 4'h4, 32'h0, 34'h0);
      sewc_wake_partner_i.clear_flags();
      bus(1'h1, 4'h0, 32'h2, 34'h0);
      bus(1'h1, 4'h8, 32'h7F, 34'h0);
      sewc_wake_partner_i.raise_flag(4, 1'h1, 0);
      repeat (3) @(posedge ref_clk_in);
      do_sleep(1'h0);
      bus(1'h0, 4'h4, 32'h0, 34'h0);
      sewc_wake_partner_i.clear_flags();
      bus(1'h1, 4'h0, 32'h6, 34'h0);
      do_sleep(1'h1);
      sewc_wake_partner_i.raise_flag($urandom_range(6, 0), 1'h1, 0);
      wait_wake(n);
      chk("start-up wait", 34'h1, {33'h0, n >= 1024 && n < 1040});
      sewc_wake_partner_i.clear_flags();
      bus(1'h1, 4'h0, 32'h2, 34'h0);
      do_sleep(1'h1);
      @(posedge ref_clk_in);
      c0 = clr_cnt;
      fork
         sewc_wake_partner_i.pin_reset(8);
         begin
            repeat (7) @(posedge ref_clk_in);
            chk("pin reset", 34'h1, {33'h0, core_reset_out});
         end
      join
      wait_wake(n);
      repeat (3) @(posedge ref_clk_in);
      bus(1'h0, 4'hC, 32'h0, 34'h1);
      chk("pin wake clear", 34'h1, {33'h0, clr_cnt > c0});
      repeat (5) @(posedge ref_clk_in);
      chk("leftover notes", 34'h0, 34'(rdq.size() + pfq.size() + vq.size()));
      end_sim();
   end
endmodule
`default_nettype wire
